// file: hw/brp_pkg.sv
// Shared constants and types of the request and response phase block.
package brp_pkg;

	// ============================================================
	// Clock and reset timing
	localparam int CLK_PERIOD_NS    = 10;
	localparam int WARM_RESET_NS    = 1000;
	localparam int POR_RESET_NS     = 1000000;
	localparam int WARM_RESET_CYC   =
		(WARM_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RELEASE_MAX_CLKS = 2;
	localparam int SELFTEST_CYC     = 16;

	// ============================================================
	// Request phase encodings
	localparam logic [4:0] CMD_DEF_REPLY = 5'h00;
	localparam logic [4:0] CMD_INTA      = 5'h08;
	localparam logic [4:0] CMD_BTM       = 5'h09;
	localparam logic [4:0] CMD_IO_RD     = 5'h10;
	localparam logic [4:0] CMD_IO_WR     = 5'h11;
	localparam logic [1:0] SUB_INTA      = 2'h0;
	localparam logic [1:0] SUB_SPECIAL   = 2'h1;
	localparam logic [2:0] CMD_B_RSVD    = 3'h0;

	localparam logic [1:0] LEN_0_8  = 2'h0;
	localparam logic [1:0] LEN_16   = 2'h1;
	localparam logic [1:0] LEN_32   = 2'h2;
	localparam logic [1:0] LEN_RSVD = 2'h3;
	localparam logic [5:0] BYTES_8  = 6'h08;
	localparam logic [5:0] BYTES_16 = 6'h10;
	localparam logic [5:0] BYTES_32 = 6'h20;
	localparam logic [5:0] BYTES_0  = 6'h00;

	// ============================================================
	// Response status encodings
	localparam logic [2:0] RS_IDLE     = 3'h0;
	localparam logic [2:0] RS_RETRY    = 3'h1;
	localparam logic [2:0] RS_DEFER    = 3'h2;
	localparam logic [2:0] RS_RSVD     = 3'h3;
	localparam logic [2:0] RS_HARD     = 3'h4;
	localparam logic [2:0] RS_NODATA   = 3'h5;
	localparam logic [2:0] RS_IWB      = 3'h6;
	localparam logic [2:0] RS_DATA     = 3'h7;

	// ============================================================
	// Power-on configuration straps and reset vectors
	localparam int CFG_W     = 5;
	localparam int CFG_ADDR_ERROR  = 0;
	localparam int CFG_BUS_INITIALIZE = 1;
	localparam int CFG_TRI   = 2;
	localparam int CFG_SELF_TEST  = 3;
	localparam int CFG_VEC   = 4;
	localparam logic [CFG_W-1:0] CFG_RESET = 5'h00;
	localparam logic [35:0] VEC_LO = 36'h0_000f_fff0;
	localparam logic [35:0] VEC_HI = 36'h0_ffff_fff0;

	typedef enum logic [3:0] {
		K_DEF_REPLY, K_INTA, K_SPECIAL, K_BTM, K_IO_RD, K_IO_WR,
		K_MEM_RDINV, K_MEM_CODE_RD, K_MEM_DATA_RD, K_MEM_WR, K_RSVD
	} brp_kind_t;

endpackage : brp_pkg

// file: hw/brp_req_if.sv
// Carrier between the request receiver and the transaction decoder.
`timescale 1ns/1ns
`default_nettype none
interface brp_req_if;
	import brp_pkg::*;
	logic [4:0] cmd_a;
	logic [4:0] cmd_b;
	brp_kind_t  kind;
	logic [1:0] len;
	logic [5:0] len_bytes;
	logic       len_rsvd;
	logic [1:0] addr_size;
	logic [1:0] data_size;
	logic       write_retry;
	modport dec (input cmd_a, cmd_b, output kind, len, len_bytes,
		len_rsvd, addr_size, data_size, write_retry);
	modport core (output cmd_a, cmd_b, input kind, len, len_bytes,
		len_rsvd, addr_size, data_size, write_retry);
endinterface : brp_req_if
`default_nettype wire

// file: hw/brp_req_decode.sv
// Decoder from the two request clocks to a transaction kind and fields.
`timescale 1ns/1ns
`default_nettype none
module brp_req_decode
(
	brp_req_if.dec dif
);
	import brp_pkg::*;

	// ============================================================
	// Field selection
	wire logic [1:0] sub    = dif.cmd_b[2:1];
	wire logic       is_mem = |dif.cmd_a[2:1];
	brp_kind_t       mem_kind;
	brp_kind_t       sp_kind;
	brp_kind_t       inta_kind;
	brp_kind_t       btm_kind;

	// ============================================================
	// Kind decode
	assign mem_kind = !dif.cmd_a[2] ?
		(dif.cmd_a[0] ? K_RSVD : K_MEM_RDINV) :
		dif.cmd_a[0] ? K_MEM_WR :
		dif.cmd_a[1] ? K_MEM_DATA_RD : K_MEM_CODE_RD;
	assign inta_kind = (sub == SUB_INTA) ? K_INTA :
		(sub == SUB_SPECIAL) ? K_SPECIAL : K_RSVD;
	assign btm_kind = (sub == SUB_INTA) ? K_BTM : K_RSVD;
	assign sp_kind = (dif.cmd_a == CMD_DEF_REPLY) ? K_DEF_REPLY :
		(dif.cmd_a == CMD_INTA) ? inta_kind :
		(dif.cmd_a == CMD_BTM) ? btm_kind :
		(dif.cmd_a == CMD_IO_RD) ? K_IO_RD :
		(dif.cmd_a == CMD_IO_WR) ? K_IO_WR : K_RSVD;
	assign dif.kind = is_mem ? mem_kind : sp_kind;

	// ============================================================
	// Length and size fields
	assign dif.len = dif.cmd_b[1:0];
	assign dif.len_bytes = (dif.len == LEN_0_8) ? BYTES_8 :
		(dif.len == LEN_16) ? BYTES_16 :
		(dif.len == LEN_32) ? BYTES_32 : BYTES_0;
	assign dif.len_rsvd    = (dif.len == LEN_RSVD);
	assign dif.addr_size   = is_mem ? dif.cmd_a[4:3] : 2'h0;
	assign dif.data_size   = dif.cmd_b[4:3];
	assign dif.write_retry = is_mem & (&dif.cmd_a[2:0]);

endmodule : brp_req_decode
`default_nettype wire

// file: hw/brp_bus_phase.sv
// Request and response phase logic of one bus agent.
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - Owner drives command in both request clocks.
// - Second clock: reserved top bits, length low.
// - Length codes 8, 16, 32 bytes, reserved.
// - Request parity covers strobe and command.
// - Parity high when even count of lows.
// - Parity error asserts address error if enabled.
// - Decode reply, interrupt, trace, I/O codes.
// - Decode memory kinds, address size, retriable.
// - Reset invalidates caches, discards modified lines.
// - Outputs released within two clocks of reset.
// - Capture straps, self-test, fetch reset vector.
// - Response status encoding; retry means reissue.
// - Response parity over status; idle reads high.
// - Response parity error may assert bus init.
module brp_bus_phase
#(
	parameter int SELFTEST_CYCLES = brp_pkg::SELFTEST_CYC
)
(
	input  wire logic                    core_clk,
	input  wire logic                    resetn,
	input  wire logic                    iss_valid,
	output logic                         iss_ready,
	input  wire logic [4:0]              iss_cmd_first,
	input  wire logic [1:0]              iss_len,
	input  wire logic                    bus_owner,
	input  wire logic                    ads_lvl_n,
	output logic                         ads_drv_n,
	output logic                         ads_oe_n,
	input  wire logic [4:0]              req_cmd_lvl_n,
	output logic      [4:0]              req_cmd_drv_n,
	output logic                         req_cmd_oe_n,
	input  wire logic                    req_parity_lvl_n,
	output logic                         req_parity_drv_n,
	output logic                         req_parity_oe_n,
	output logic                         addr_error_drv_n,
	output logic                         addr_error_oe_n,
	input  wire logic [2:0]              resp_status_lvl_n,
	input  wire logic                    resp_parity_lvl_n,
	output logic                         bus_initialize_drv_n,
	output logic                         bus_initialize_oe_n,
	input  wire logic [brp_pkg::CFG_W-1:0] cfg_straps_lvl_n,
	input  wire logic                    head_snoop_hit_modified,
	input  wire logic                    head_defer,
	input  wire logic                    head_write,
	output logic                         rx_valid,
	output brp_pkg::brp_kind_t           rx_kind,
	output logic      [4:0]              rx_first,
	output logic      [5:0]              rx_len_bytes,
	output logic                         rx_len_rsvd,
	output logic      [1:0]              rx_addr_size,
	output logic      [1:0]              rx_data_size,
	output logic                         rx_write_retry,
	output logic                         req_parity_err,
	output logic                         resp_valid,
	output logic      [2:0]              resp_code,
	output logic                         resp_retry,
	output logic                         resp_parity_err,
	output logic                         resp_illegal,
	output logic                         cache_inv,
	output logic                         self_test_busy,
	output logic                         fetch_start,
	output logic      [35:0]             fetch_vector,
	output logic                         outputs_off
);
	import brp_pkg::*;

	typedef enum logic [1:0] {ISS_IDLE, ISS_FIRST, ISS_SECOND} brp_iss_t;
	typedef enum logic {RX_IDLE, RX_SECOND} brp_rx_t;
	typedef enum logic [1:0] {
		BOOT_CFG, BOOT_TEST, BOOT_RUN, BOOT_OFF
	} brp_boot_t;

	brp_iss_t          iss_st_ff;
	brp_rx_t           rx_st_ff;
	brp_boot_t         boot_ff;
	logic [1:0]        len_ff;
	logic [4:0]        rx_a_ff;
	logic              pa_err_ff;
	logic              prev_nz_ff;
	logic [CFG_W-1:0]  cfg_ff;
	logic [15:0]       test_cnt_ff;
	brp_req_if         dif ();

	// ============================================================
	// Request issue: strobe and command over two clocks
	wire logic accept   = iss_valid & iss_ready;
	wire logic [4:0] cmd_b_n = ~{CMD_B_RSVD, len_ff};
	wire logic nxt_ads_n = !accept;
	wire logic [4:0] nxt_cmd_n = accept ? ~iss_cmd_first : cmd_b_n;
	wire logic nxt_drive = accept | (iss_st_ff == ISS_FIRST);
	wire logic nxt_par_n = ~^{nxt_ads_n, nxt_cmd_n};

	assign iss_ready = (iss_st_ff == ISS_IDLE) && bus_owner &&
		(boot_ff == BOOT_RUN);

	brp_req_decode u_dec (.dif(dif));

	always_ff @(posedge core_clk)
	begin
		if (!resetn)
			iss_st_ff <= ISS_IDLE;
		else
			unique case (iss_st_ff)
				ISS_IDLE:   iss_st_ff <= accept ? ISS_FIRST : ISS_IDLE;
				ISS_FIRST:  iss_st_ff <= ISS_SECOND;
				ISS_SECOND: iss_st_ff <= ISS_IDLE;
			endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (!resetn)
		begin
			ads_drv_n        <= 1'b1;
			ads_oe_n         <= 1'b1;
			req_cmd_drv_n    <= 5'h1f;
			req_cmd_oe_n     <= 1'b1;
			req_parity_drv_n <= 1'b1;
			req_parity_oe_n  <= 1'b1;
			len_ff           <= LEN_0_8;
		end
		else
		begin
			ads_drv_n        <= nxt_ads_n | !nxt_drive;
			ads_oe_n         <= !nxt_drive;
			req_cmd_drv_n    <= nxt_drive ? nxt_cmd_n : 5'h1f;
			req_cmd_oe_n     <= !nxt_drive;
			req_parity_drv_n <= nxt_drive ? nxt_par_n : 1'b1;
			req_parity_oe_n  <= !nxt_drive;
			if (accept)
				len_ff <= iss_len;
		end
	end

	// ============================================================
	// Request receive, parity check and error phase drive
	wire logic par_bad = req_parity_lvl_n !=
		~^{ads_lvl_n, req_cmd_lvl_n};
	wire logic rx_start = (rx_st_ff == RX_IDLE) && !ads_lvl_n;
	wire logic rx_done  = (rx_st_ff == RX_SECOND);
	wire logic rx_perr  = rx_done & (pa_err_ff | par_bad);
	wire logic addr_error_go  = rx_perr & cfg_ff[CFG_ADDR_ERROR] & !cfg_ff[CFG_TRI];

	assign dif.cmd_a = rx_a_ff;
	assign dif.cmd_b = ~req_cmd_lvl_n;

	always_ff @(posedge core_clk)
	begin
		if (!resetn)
			rx_st_ff <= RX_IDLE;
		else
			rx_st_ff <= rx_start ? RX_SECOND : RX_IDLE;
	end

	always_ff @(posedge core_clk)
	begin
		if (!resetn)
		begin
			rx_a_ff   <= 5'h00;
			pa_err_ff <= 1'b0;
		end
		else if (rx_start)
		begin
			rx_a_ff   <= ~req_cmd_lvl_n;
			pa_err_ff <= par_bad;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!resetn)
		begin
			rx_valid         <= 1'b0;
			req_parity_err   <= 1'b0;
			addr_error_drv_n <= 1'b1;
			addr_error_oe_n  <= 1'b1;
		end
		else
		begin
			rx_valid         <= rx_done;
			req_parity_err   <= rx_perr;
			addr_error_drv_n <= !addr_error_go;
			addr_error_oe_n  <= !addr_error_go;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!resetn)
		begin
			rx_kind        <= K_RSVD;
			rx_first       <= 5'h00;
			rx_len_bytes   <= BYTES_0;
			rx_len_rsvd    <= 1'b0;
			rx_addr_size   <= 2'h0;
			rx_data_size   <= 2'h0;
			rx_write_retry <= 1'b0;
		end
		else if (rx_done)
		begin
			rx_kind        <= dif.kind;
			rx_first       <= rx_a_ff;
			rx_len_bytes   <= dif.len_bytes;
			rx_len_rsvd    <= dif.len_rsvd;
			rx_addr_size   <= dif.addr_size;
			rx_data_size   <= dif.data_size;
			rx_write_retry <= dif.write_retry;
		end
	end

	// ============================================================
	// Response monitor: status, parity and legality
	wire logic [2:0] rs  = ~resp_status_lvl_n;
	wire logic rs_nz     = |rs;
	wire logic rsp_bad   = resp_parity_lvl_n != ^resp_status_lvl_n;
	wire logic clean     = !head_snoop_hit_modified & !head_defer;
	wire logic legal     =
		(rs == RS_RETRY || rs == RS_DEFER) ? !head_snoop_hit_modified & head_defer :
		(rs == RS_HARD) ? 1'b1 :
		(rs == RS_NODATA) ? clean & head_write :
		(rs == RS_DATA) ? clean & !head_write :
		(rs == RS_IWB) ? head_snoop_hit_modified : 1'b0;
	wire logic illegal   = rs_nz & (!legal | prev_nz_ff);
	wire logic bus_initialize_go  = rsp_bad & cfg_ff[CFG_BUS_INITIALIZE] & !cfg_ff[CFG_TRI];

	always_ff @(posedge core_clk)
	begin
		if (!resetn)
		begin
			prev_nz_ff      <= 1'b0;
			resp_valid      <= 1'b0;
			resp_code       <= RS_IDLE;
			resp_retry      <= 1'b0;
			resp_parity_err <= 1'b0;
			resp_illegal    <= 1'b0;
		end
		else
		begin
			prev_nz_ff      <= rs_nz;
			resp_valid      <= rs_nz;
			resp_code       <= rs;
			resp_retry      <= (rs == RS_RETRY);
			resp_parity_err <= rsp_bad;
			resp_illegal    <= illegal;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!resetn)
		begin
			bus_initialize_drv_n <= 1'b1;
			bus_initialize_oe_n  <= 1'b1;
		end
		else
		begin
			bus_initialize_drv_n <= !bus_initialize_go;
			bus_initialize_oe_n  <= !bus_initialize_go;
		end
	end

	// ============================================================
	// Reset, configuration capture, self-test and fetch start
	wire logic [CFG_W-1:0] nxt_cfg = ~cfg_straps_lvl_n;
	wire logic test_end = (test_cnt_ff == 16'(SELFTEST_CYCLES - 1));

	always_ff @(posedge core_clk)
	begin
		if (!resetn)
		begin
			boot_ff     <= BOOT_CFG;
			cfg_ff      <= CFG_RESET;
			test_cnt_ff <= 16'h0000;
			fetch_start <= 1'b0;
		end
		else
		begin
			fetch_start <= 1'b0;
			unique case (boot_ff)
				BOOT_CFG:
				begin
					cfg_ff <= nxt_cfg;
					boot_ff <= nxt_cfg[CFG_TRI] ? BOOT_OFF :
						nxt_cfg[CFG_SELF_TEST] ? BOOT_TEST : BOOT_RUN;
					fetch_start <= !nxt_cfg[CFG_TRI] & !nxt_cfg[CFG_SELF_TEST];
				end
				BOOT_TEST:
				begin
					test_cnt_ff <= test_cnt_ff + 16'h0001;
					if (test_end)
					begin
						boot_ff <= BOOT_RUN;
						fetch_start <= 1'b1;
					end
				end
				BOOT_RUN: boot_ff <= BOOT_RUN;
				BOOT_OFF: boot_ff <= BOOT_OFF;
			endcase
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!resetn)
		begin
			cache_inv    <= 1'b1;
			fetch_vector <= VEC_LO;
		end
		else
		begin
			cache_inv <= 1'b0;
			if (boot_ff == BOOT_CFG)
				fetch_vector <= nxt_cfg[CFG_VEC] ? VEC_HI : VEC_LO;
		end
	end

	assign self_test_busy = (boot_ff == BOOT_TEST);
	assign outputs_off    = cfg_ff[CFG_TRI];

	// ============================================================
	// Assertions
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	a_second_clk_cmd: assert property (
		!ads_drv_n |=> ads_drv_n && !req_cmd_oe_n &&
		req_cmd_drv_n[4:2] == 3'h7 &&
		req_cmd_drv_n[1:0] == ~$past(iss_len, 2))
		else $error("second request clock content wrong");

	a_req_par_gen: assert property (
		!req_parity_oe_n |->
		req_parity_drv_n == ~^{ads_drv_n, req_cmd_drv_n})
		else $error("request parity driven wrong");

	a_addr_error_on_perr: assert property (
		req_parity_err |->
		addr_error_oe_n == !(cfg_ff[CFG_ADDR_ERROR] & !cfg_ff[CFG_TRI]))
		else $error("address error drive wrong");

	a_decode_io_read: assert property (
		rx_valid && rx_first == CMD_IO_RD |-> rx_kind == K_IO_RD)
		else $error("I/O read decode wrong");

	a_len_sixteen: assert property (
		rx_done && dif.cmd_b[1:0] == LEN_16 |=> rx_len_bytes == BYTES_16)
		else $error("length 16 decode wrong");

	a_mem_write_kind: assert property (
		rx_valid && |rx_first[2:1] && rx_first[2] && rx_first[0] |->
		rx_kind == K_MEM_WR && rx_write_retry == rx_first[1])
		else $error("memory write decode wrong");

	a_reset_release: assert property (
		@(posedge core_clk) disable iff (1'b0)
		!resetn |=> ads_oe_n && req_cmd_oe_n &&
		req_parity_oe_n && addr_error_oe_n && bus_initialize_oe_n &&
		cache_inv)
		else $error("outputs not released under reset");

	a_fetch_vector: assert property (
		fetch_start |-> !cfg_ff[CFG_TRI] &&
		fetch_vector == (cfg_ff[CFG_VEC] ? VEC_HI : VEC_LO))
		else $error("fetch start or vector wrong");

	a_resp_par_check: assert property (
		resp_parity_err == $past(resp_parity_lvl_n != ^resp_status_lvl_n))
		else $error("response parity check wrong");

	a_bus_initialize_on_perr: assert property (
		resp_parity_err && cfg_ff[CFG_BUS_INITIALIZE] && !cfg_ff[CFG_TRI] |->
		!bus_initialize_oe_n && !bus_initialize_drv_n)
		else $error("bus initialize not driven");

	a_resp_retry: assert property (
		resp_retry |-> resp_valid && resp_code == RS_RETRY)
		else $error("retry flag wrong");

	a_resp_two_clk: assert property (
		resp_valid ##1 resp_valid |-> resp_illegal)
		else $error("long response not flagged");

endmodule : brp_bus_phase
`default_nettype wire

// file: hw/brp_placeholder_none.sv
// Intentionally empty compilation unit.
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// file: dv/brp_peer_model.sv
// Peer bus agent model that issues requests and drives response status.
`timescale 1ns/1ns
`default_nettype none
module brp_peer_model
(
	input  wire logic       core_clk,
	input  wire logic       resetn,
	input  wire logic       go_req,
	input  wire logic [4:0] first,
	input  wire logic [4:0] second,
	input  wire logic       bad_req,
	input  wire logic       go_rsp,
	input  wire logic [2:0] code,
	input  wire logic       bad_rsp,
	output logic            ads_n_ff,
	output logic      [4:0] cmd_n_ff,
	output logic            par_n_ff,
	output logic      [2:0] rs_n_ff,
	output logic            rsp_n_ff
);
	logic second_ff;
	// ============================================================
	// Request phase
	// Released lines sit at the pull-up level.
	always_ff @(posedge core_clk)
	begin
		if (!resetn)
		begin
			second_ff <= 1'b0;
			ads_n_ff  <= 1'b1;
			cmd_n_ff  <= 5'h1f;
			par_n_ff  <= 1'b1;
		end
		else if (go_req && !second_ff)
		begin
			second_ff <= 1'b1;
			ads_n_ff  <= 1'b0;
			cmd_n_ff  <= ~first;
			par_n_ff  <= ~^{1'b0, ~first} ^ bad_req;
		end
		else if (second_ff)
		begin
			second_ff <= 1'b0;
			ads_n_ff  <= 1'b1;
			cmd_n_ff  <= ~second;
			par_n_ff  <= ~^{1'b1, ~second} ^ bad_req;
		end
		else
		begin
			ads_n_ff <= 1'b1;
			cmd_n_ff <= 5'h1f;
			par_n_ff <= 1'b1;
		end
	end
	// ============================================================
	// Response phase
	// Status stands only while commanded; idle reads high.
	always_ff @(posedge core_clk)
	begin
		if (!resetn)
		begin
			rs_n_ff  <= 3'h7;
			rsp_n_ff <= 1'b1;
		end
		else
		begin
			rs_n_ff  <= go_rsp ? ~code : 3'h7;
			rsp_n_ff <= go_rsp ? (^(~code)) ^ bad_rsp : 1'b1;
		end
	end
endmodule : brp_peer_model
`default_nettype wire

// file: dv/tb_bus_request_response_phase.sv
// Self-checking bench of the request and response phase block.
`timescale 1ns/1ns
`default_nettype none
module tb_bus_request_response_phase;
	import brp_pkg::*;
	localparam int ST_CYC = 2;
	logic core_clk, resetn, iss_valid, bus_owner, ads_lvl_n, req_parity_lvl_n;
	logic head_snoop_hit_modified, head_defer, head_write, iss_ready, ads_drv_n, ads_oe_n;
	logic req_cmd_oe_n, req_parity_drv_n, req_parity_oe_n, addr_error_drv_n;
	logic addr_error_oe_n, bus_initialize_drv_n, bus_initialize_oe_n;
	logic rx_valid, rx_len_rsvd, rx_write_retry, req_parity_err, resp_valid;
	logic resp_retry, resp_parity_err, resp_illegal, cache_inv, outputs_off;
	logic self_test_busy, fetch_start, go_req, bad_req, go_rsp, bad_rsp;
	logic p_ads_n, p_par_n, p_rsp_n, addr_error_on, bus_initialize_on;
	logic [4:0] iss_cmd_first, req_cmd_lvl_n, req_cmd_drv_n, rx_first;
	logic [4:0] cfg_straps_lvl_n, p_first, p_second, p_cmd_n;
	logic [2:0] resp_code, p_code, p_rs_n;
	logic [1:0] iss_len, rx_addr_size, rx_data_size;
	logic [5:0] rx_len_bytes;
	logic [35:0] fetch_vector;
	brp_kind_t rx_kind;
	logic [31:0] seed = 32'hc5b0_f5d4;
	int failures, cmp_count, cyc;
	// ============================================================
	// Wires, design and peer
	assign ads_lvl_n = p_ads_n & (ads_oe_n | ads_drv_n);
	assign req_cmd_lvl_n = p_cmd_n & ({5{req_cmd_oe_n}} | req_cmd_drv_n);
	assign req_parity_lvl_n = p_par_n & (req_parity_oe_n | req_parity_drv_n);
	brp_bus_phase #(.SELFTEST_CYCLES(ST_CYC)) i_brp_bus_phase (.core_clk,
		.resetn, .iss_valid, .iss_ready, .iss_cmd_first, .iss_len, .bus_owner,
		.ads_lvl_n, .ads_drv_n, .ads_oe_n, .req_cmd_lvl_n, .req_cmd_drv_n,
		.req_cmd_oe_n, .req_parity_lvl_n, .req_parity_drv_n, .req_parity_oe_n,
		.addr_error_drv_n, .addr_error_oe_n, .resp_status_lvl_n(p_rs_n),
		.resp_parity_lvl_n(p_rsp_n), .bus_initialize_drv_n,
		.bus_initialize_oe_n, .cfg_straps_lvl_n, .head_snoop_hit_modified, .head_defer,
		.head_write, .rx_valid, .rx_kind, .rx_first, .rx_len_bytes,
		.rx_len_rsvd, .rx_addr_size, .rx_data_size, .rx_write_retry,
		.req_parity_err, .resp_valid, .resp_code, .resp_retry,
		.resp_parity_err, .resp_illegal, .cache_inv, .self_test_busy,
		.fetch_start, .fetch_vector, .outputs_off);
	brp_peer_model i_brp_peer_model (.core_clk, .resetn, .go_req,
		.first(p_first), .second(p_second), .bad_req, .go_rsp, .code(p_code),
		.bad_rsp, .ads_n_ff(p_ads_n), .cmd_n_ff(p_cmd_n), .par_n_ff(p_par_n),
		.rs_n_ff(p_rs_n), .rsp_n_ff(p_rsp_n));
	// ============================================================
	// Reference model and checks
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	function automatic brp_kind_t exp_kind(input logic [4:0] f,
		input logic [4:0] s);
		if (f == CMD_DEF_REPLY) return K_DEF_REPLY;
		if (f == CMD_INTA) return (s[2:1] == SUB_INTA) ? K_INTA :
			(s[2:1] == SUB_SPECIAL) ? K_SPECIAL : K_RSVD;
		if (f == CMD_BTM) return (s[2:1] == 2'h0) ? K_BTM : K_RSVD;
		if (f == CMD_IO_RD) return K_IO_RD;
		if (f == CMD_IO_WR) return K_IO_WR;
		if (f[2:1] == 2'h0) return K_RSVD;
		if (f[2:0] == 3'h2) return K_MEM_RDINV;
		if (f[2:0] == 3'h3) return K_RSVD;
		if (f[0]) return K_MEM_WR;
		return f[1] ? K_MEM_DATA_RD : K_MEM_CODE_RD;
	endfunction : exp_kind
	function automatic logic exp_legal(input int c, input logic h, d, w);
		case (c)
			1, 2: return !h && d;
			3: return 1'b0;
			5: return !h && !d && w;
			6: return h;
			7: return !h && !d && !w;
			default: return 1'b1;
		endcase
	endfunction : exp_legal
	task automatic chk(input string what, input logic [35:0] exp, got);
		cmp_count++;
		if (got !== exp)
		begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : print_verdict
	// ============================================================
	// Stimulus tasks
	task automatic do_reset(input logic [4:0] s, input int n);
		logic busy_seen;
		busy_seen = 1'b0;
		@(posedge core_clk) resetn <= 1'b0;
		cfg_straps_lvl_n <= s;
		iss_valid <= 1'b0;
		addr_error_on = !s[0] && s[2];
		bus_initialize_on = !s[1] && s[2];
		repeat (2) @(posedge core_clk);
		@(negedge core_clk);
		chk("oe_n", 5'h1f, {ads_oe_n, req_cmd_oe_n, req_parity_oe_n,
			addr_error_oe_n, bus_initialize_oe_n});
		chk("cache_inv", 1'b1, cache_inv);
		repeat (n - 2) @(posedge core_clk);
		resetn <= 1'b1;
		for (int i = 0; i < ST_CYC + 10 && fetch_start !== 1'b1; i++)
		begin
			@(negedge core_clk);
			busy_seen = busy_seen | (self_test_busy === 1'b1);
		end
		if (s[2])
		begin
			chk("fetch", 1'b1, fetch_start);
			chk("vector", s[4] ? VEC_LO : VEC_HI, fetch_vector);
			chk("self_test", !s[3], busy_seen);
		end
		chk("outputs_off", !s[2], outputs_off);
		chk("cache_inv", 1'b0, cache_inv);
	endtask : do_reset
	task automatic issue(input logic [4:0] f, input logic [1:0] len);
		@(posedge core_clk) iss_cmd_first <= f;
		iss_len <= len;
		iss_valid <= 1'b1;
		for (int i = 0; i < 20; i++)
		begin
			@(negedge core_clk);
			if (iss_ready === 1'b1) break;
		end
		@(posedge core_clk) iss_valid <= 1'b0;
		@(negedge core_clk);
		chk("first", {1'b0, ~f, ~^{1'b0, ~f}},
			{ads_lvl_n, req_cmd_lvl_n, req_parity_lvl_n});
		@(negedge core_clk);
		chk("second", {1'b1, 3'h7, ~len, ~^{1'b1, 3'h7, ~len}},
			{ads_lvl_n, req_cmd_lvl_n, req_parity_lvl_n});
		@(negedge core_clk);
		chk("release", 3'h7, {ads_oe_n, req_cmd_oe_n, req_parity_oe_n});
	endtask : issue
	task automatic recv(input logic [4:0] f, s, input logic bad);
		brp_kind_t k;
		k = exp_kind(f, s);
		@(posedge core_clk) go_req <= 1'b1;
		p_first <= f;
		p_second <= s;
		bad_req <= bad;
		@(posedge core_clk) go_req <= 1'b0;
		for (int i = 0; i < 6; i++)
		begin
			@(negedge core_clk);
			if (rx_valid === 1'b1) break;
		end
		chk("rx_valid", 1'b1, rx_valid);
		chk("rx_kind", k, rx_kind);
		chk("rx_first", f, rx_first);
		chk("rx_len", (s[1:0] == LEN_0_8) ? BYTES_8 : (s[1:0] == LEN_16) ?
			BYTES_16 : (s[1:0] == LEN_32) ? BYTES_32 : BYTES_0, rx_len_bytes);
		chk("len_rsvd", s[1:0] == LEN_RSVD, rx_len_rsvd);
		chk("data_size", s[4:3], rx_data_size);
		if (k >= K_MEM_RDINV && k <= K_MEM_WR)
			chk("addr_size", f[4:3], rx_addr_size);
		if (k == K_MEM_WR)
			chk("retry", f[1], rx_write_retry);
		chk("par_err", bad, req_parity_err);
		chk("addr_error", !(bad && addr_error_on), addr_error_oe_n | addr_error_drv_n);
	endtask : recv
	task automatic rsp(input int c, input logic [2:0] fl, input logic bad, int n);
		@(posedge core_clk) go_rsp <= 1'b1;
		p_code <= c[2:0];
		bad_rsp <= bad;
		{head_snoop_hit_modified, head_defer, head_write} <= fl;
		repeat (n) @(posedge core_clk);
		go_rsp <= 1'b0;
		@(negedge core_clk);
		@(negedge core_clk);
		chk("resp_valid", c != 0, resp_valid);
		chk("resp_code", c[2:0], resp_code);
		chk("resp_retry", c == 1, resp_retry);
		chk("rsp_err", bad, resp_parity_err);
		chk("bus_initialize", !(bad && bus_initialize_on),
			bus_initialize_oe_n | bus_initialize_drv_n);
		chk("illegal", c != 0 && (!exp_legal(c, fl[2], fl[1], fl[0]) || n == 2),
			resp_illegal);
	endtask : rsp
	// ============================================================
	// Main sequence
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			failures++;
			print_verdict();
		end
	end
	initial
	begin
		{resetn, iss_valid, iss_cmd_first, iss_len, go_req, bad_req} = '0;
		{p_first, p_second, go_rsp, p_code, bad_rsp} = '0;
		{head_snoop_hit_modified, head_defer, head_write} = 3'h0;
		bus_owner = 1'b1;
		cfg_straps_lvl_n = 5'h1c;
		do_reset(5'h1c, 10);
		for (int i = 0; i < 4; i++) issue(5'(rnd()), i[1:0]);
		@(posedge core_clk) bus_owner <= 1'b0;
		@(negedge core_clk) chk("refuse", 1'b0, iss_ready);
		@(posedge core_clk) bus_owner <= 1'b1;
		for (int i = 0; i < 40; i++)
			recv((i < 32) ? i[4:0] : 5'(rnd()), 5'(rnd()), i % 7 == 3);
		recv(CMD_INTA, 5'h02, 1'b0);
		recv(CMD_BTM, 5'h18, 1'b0);
		for (int c = 0; c < 8; c++)
			for (int f = 0; f < 8; f++) rsp(c, f[2:0], 1'b0, 1);
		rsp(7, 3'h0, 1'b1, 1);
		rsp(0, 3'h0, 1'b1, 1);
		rsp(7, 3'h0, 1'b0, 2);
		do_reset(5'h04, WARM_RESET_CYC);
		recv(CMD_IO_WR, 5'h02, 1'b1);
		do_reset(5'h18, WARM_RESET_CYC);
		recv(CMD_IO_RD, 5'h01, 1'b1);
		rsp(5, 3'h1, 1'b1, 1);
		print_verdict();
	end
endmodule : tb_bus_request_response_phase
`default_nettype wire
